/* addr_decode_defs.vh */
// Constants for the flash partition address decoder
`ifndef ADDR_DECODE_DEFS_VH
`define ADDR_DECODE_DEFS_VH
`define SRAM_BASE 16'h0000
`define SRAM_TOP 16'h03FF
`define SRAM_RELOC_BASE 16'h8400
`define SRAM_RELOC_TOP 16'h87FF
`define DFLASH_BASE 16'h0400
`define SPACE_TOP 16'hFFFF
`define PART_CODE_DEFAULT 3'h7
`define PART_CODE_RESERVED 3'h0
`define LOCK_REGION_KB 6'h04
`define SFR_MIN 8'h80
`define SFR_MWS 8'h8F
`define SFR_HW_CONFIG_REG_ZERO 8'h91
`define SFR_HW_CONFIG_REG_ONE 8'h94
`define SFR_DIRECT 8'h95
`define HW_CONFIG_REG_ZERO_RESET 8'hFF
`define HW_CONFIG_REG_ONE_RESET 8'hFF
`define HW_CONFIG_REG_ZERO_PART_LSB 0
`define HW_CONFIG_REG_ZERO_LOCK_ALL 3
`define HW_CONFIG_REG_ZERO_LOCK_4K 4
`define HW_CONFIG_REG_ONE_EXT_LSB 0
`define MWS_WSEL 0
`define APB_MWS 12'h000
`define APB_HW_CONFIG_REG_ZERO 12'h004
`define APB_HW_CONFIG_REG_ONE 12'h008
`define APB_CTRL 12'h00C
`define APB_STATUS 12'h010
`endif

/* sfr_reg.v */
// Byte register with write-qualify input used for special-function registers
`timescale 1ns/100ps
module sfr_reg #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [7:0] wr_data,
    output reg [7:0] q_r
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q_r <= RESET_VAL;
        else if (wr_en)
            q_r <= wr_data;
    end
endmodule // sfr_reg

/* flash_partition_address_decoder.v */
// Program/data address decoder with flash partition, write gating and APB registers
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "addr_decode_defs.vh"
//
// Contract
// - A read of an undefined SFR address returns zero. Here only reads at 95 hex and above raise sfr_rd_zero_r.
// - The 1kB SRAM sits in data space from address zero for data moves.
// - With relocation set the SRAM sits at 8400 hex for both fetches and data moves.
// - Program and data space are two independent 64kB spaces 0000 to FFFF.
// - Fetches and table reads use program space, data moves use data space.
// - With on-chip memory enabled, in-range addresses go internal, others to the ports.
// - A 3-bit partition code sets data flash 32..1kB for 001..110, none for 111, 000 reserved.
// - Data flash starts at 0400 hex directly above the SRAM.
// - Program flash shrinks from the top; higher fetches go external.
// - With zero program flash every fetch goes external. Here fetches in the relocated SRAM window still go to the SRAM.
// - Data moves may read and write flash in both partitions; writes need the write-select bit. Here data-move reads of program flash go external.
// - Fetches from the data flash partition are blocked.
// - Both partitions may be erased and written in user mode, subject to locks.
// - The two hardware configuration registers accept writes only in programming mode.
// - The lock option refuses user erase/write to a 4kB region or all program flash.
// - With program flash locked, data flash stays readable, writable and erasable.
module flash_partition_address_decoder (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire prog_mode_pin,
    input wire acc_valid,
    input wire [1:0] acc_type,
    input wire acc_write,
    input wire acc_erase,
    input wire [15:0] acc_addr,
    output reg sel_sram_r,
    output reg sel_flash_r,
    output reg sel_ext_r,
    output reg [15:0] flash_offset_r,
    output reg acc_denied_r,
    output reg ext_is_prog_r,
    output reg sfr_rd_zero_r
);
    // acc_type: 0 fetch, 1 table read, 2 data move, 3 SFR direct access
    localparam [1:0] T_FETCH = 2'h0;
    localparam [1:0] T_TABLE = 2'h1;
    localparam [1:0] T_DMOVE = 2'h2;
    localparam [1:0] T_SFR = 2'h3;
    parameter [5:0] FLASH_KB = 6'h20;

    reg prog_s1;
    reg prog_s2;
    reg reloc_r;
    reg mem_en_r;
    wire [7:0] mws_q;
    wire [7:0] hw_config_reg_zero_q;
    wire [7:0] hw_config_reg_one_q;
    wire apb_wr;
    wire apb_rd;
    wire hcr_allowed;
    wire [2:0] part_code;
    wire [5:0] dm_kb;
    wire [5:0] pm_kb;
    wire [16:0] pm_top_ex;
    wire [16:0] dm_top_ex;
    wire is_prog;
    wire in_reloc;
    wire in_sram_lo;
    wire in_pflash;
    wire in_dflash;
    wire in_lock;
    wire flash_hit;
    wire write_op;
    wire deny;

    // Data flash kilobytes for a code, capped by the part size
    function [5:0] dflash_kb;
        input [2:0] code;
        input [5:0] part_kb;
        reg [5:0] raw;
        begin
            raw = 6'h00;
            case (code)
                3'h1: raw = 6'h20;
                3'h2: raw = 6'h10;
                3'h3: raw = 6'h08;
                3'h4: raw = 6'h04;
                3'h5: raw = 6'h02;
                3'h6: raw = 6'h01;
                default: raw = 6'h00;
            endcase
            dflash_kb = (raw > part_kb) ? part_kb : raw;
        end
    endfunction

    // Pin is asynchronous to pclk
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_s1 <= 1'b0;
            prog_s2 <= 1'b0;
        end
        else
        begin
            prog_s1 <= prog_mode_pin;
            prog_s2 <= prog_s1;
        end
    end

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign hcr_allowed = prog_s2;

    sfr_reg #(.RESET_VAL(8'h00)) u_mws (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && paddr == `APB_MWS),
        .wr_data(pwdata[7:0]),
        .q_r(mws_q)
    );

    sfr_reg #(.RESET_VAL(`HW_CONFIG_REG_ZERO_RESET)) u_hw_config_reg_zero (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && paddr == `APB_HW_CONFIG_REG_ZERO && hcr_allowed),
        .wr_data(pwdata[7:0]),
        .q_r(hw_config_reg_zero_q)
    );

    sfr_reg #(.RESET_VAL(`HW_CONFIG_REG_ONE_RESET)) u_hw_config_reg_one (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(apb_wr && paddr == `APB_HW_CONFIG_REG_ONE && hcr_allowed),
        .wr_data(pwdata[7:0]),
        .q_r(hw_config_reg_one_q)
    );

    // Control: bit0 relocate SRAM, bit1 on-chip memory enable
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reloc_r <= 1'b0;
            mem_en_r <= 1'b1;
        end
        else if (apb_wr && paddr == `APB_CTRL)
        begin
            reloc_r <= pwdata[0];
            mem_en_r <= pwdata[1];
        end
    end

    // APB answers in the access cycle; unmapped reads zero, writes dropped
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `APB_MWS: prdata <= {24'h000000, mws_q};
                    `APB_HW_CONFIG_REG_ZERO: prdata <= {24'h000000, hw_config_reg_zero_q};
                    `APB_HW_CONFIG_REG_ONE: prdata <= {24'h000000, hw_config_reg_one_q};
                    `APB_CTRL: prdata <= {30'h00000000, mem_en_r, reloc_r};
                    `APB_STATUS: prdata <= {16'h0000, 2'h0, pm_kb, 5'h00, part_code};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign part_code = hw_config_reg_zero_q[`HW_CONFIG_REG_ZERO_PART_LSB +: 3];
    assign dm_kb = (part_code == `PART_CODE_RESERVED) ? 6'h00 : dflash_kb(part_code, FLASH_KB);
    assign pm_kb = FLASH_KB - dm_kb;
    assign pm_top_ex = {1'b0, pm_kb, 10'h000};
    assign dm_top_ex = {1'b0, dm_kb, 10'h000} + {1'b0, `DFLASH_BASE};

    assign is_prog = (acc_type == T_FETCH) || (acc_type == T_TABLE);
    assign in_reloc = reloc_r && acc_addr >= `SRAM_RELOC_BASE && acc_addr <= `SRAM_RELOC_TOP;
    assign in_sram_lo = !reloc_r && !is_prog && acc_addr <= `SRAM_TOP;
    assign in_pflash = is_prog && ({1'b0, acc_addr} < pm_top_ex);
    assign in_dflash = !is_prog && acc_addr >= `DFLASH_BASE
        && ({1'b0, acc_addr} < dm_top_ex);
    assign in_lock = hw_config_reg_zero_q[`HW_CONFIG_REG_ZERO_LOCK_ALL] == 1'b0
        || (hw_config_reg_zero_q[`HW_CONFIG_REG_ZERO_LOCK_4K] == 1'b0 && acc_addr[15:12] == 4'h0);
    assign flash_hit = mem_en_r && (in_pflash || in_dflash);
    assign write_op = acc_write || acc_erase;
    // Data move may also target program flash region via acc_addr below pm_top
    assign deny = acc_type == T_SFR ? 1'b0
        : (acc_type == T_DMOVE && write_op && !mws_q[`MWS_WSEL])
        || (acc_type == T_DMOVE && write_op && !in_dflash && in_lock
            && ({1'b0, acc_addr} < pm_top_ex))
        || (is_prog && write_op);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_sram_r <= 1'b0;
            sel_flash_r <= 1'b0;
            sel_ext_r <= 1'b0;
            flash_offset_r <= 16'h0000;
            acc_denied_r <= 1'b0;
            ext_is_prog_r <= 1'b0;
            sfr_rd_zero_r <= 1'b0;
        end
        else
        begin
            sel_sram_r <= 1'b0;
            sel_flash_r <= 1'b0;
            sel_ext_r <= 1'b0;
            acc_denied_r <= 1'b0;
            ext_is_prog_r <= 1'b0;
            sfr_rd_zero_r <= 1'b0;
            if (acc_valid && acc_type == T_SFR)
            begin
                sfr_rd_zero_r <= !acc_write && acc_addr[7:0] >= `SFR_DIRECT;
            end
            else if (acc_valid)
            begin
                if (mem_en_r && (in_reloc || in_sram_lo))
                    sel_sram_r <= 1'b1;
                else if (flash_hit)
                begin
                    sel_flash_r <= !deny;
                    acc_denied_r <= deny;
                    flash_offset_r <= in_dflash
                        ? acc_addr - `DFLASH_BASE + pm_top_ex[15:0]
                        : acc_addr;
                end
                else if (!is_prog && write_op && ({1'b0, acc_addr} < pm_top_ex) && mem_en_r)
                begin
                    // Data move into program flash region
                    sel_flash_r <= !deny;
                    acc_denied_r <= deny;
                    flash_offset_r <= acc_addr;
                end
                else
                begin
                    sel_ext_r <= 1'b1;
                    ext_is_prog_r <= is_prog;
                end
            end
        end
    end
endmodule // flash_partition_address_decoder

/* fpad_props.sv */
// Port-level assertions for the flash partition address decoder
`timescale 1ns/100ps
module fpad_props #(
    parameter [5:0] FLASH_KB = 6'h20
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire acc_valid,
    input wire [1:0] acc_type,
    input wire acc_write,
    input wire [15:0] acc_addr,
    input wire sel_sram_r,
    input wire sel_flash_r,
    input wire sel_ext_r,
    input wire ext_is_prog_r,
    input wire sfr_rd_zero_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Above all flash and the relocated sram window; valid while FLASH_KB stays from 32 to 61
    wire [15:0] hi = {FLASH_KB, 10'h000} + 16'h0800;
    wire fetch = acc_valid && acc_type == 2'h0;
    wire dmove = acc_valid && acc_type == 2'h2;
    wire sfr = acc_valid && acc_type == 2'h3;
    wire undef_rd = sfr && !acc_write && acc_addr[7:0] >= 8'h95;
    a_one_target: assert property ($onehot0({sel_sram_r, sel_flash_r, sel_ext_r}))
        else $error("several targets selected");
    a_idle_quiet: assert property (!acc_valid |=> !(sel_sram_r || sel_flash_r || sel_ext_r))
        else $error("target selected without an access");
    a_fetch_low: assert property (fetch && acc_addr < 16'h0400 |=> !sel_sram_r)
        else $error("fetch reached data sram");
    a_data_high: assert property (dmove && acc_addr >= hi |=> sel_ext_r && !ext_is_prog_r)
        else $error("high data move not external");
    a_fetch_high: assert property (fetch && acc_addr >= hi |=> sel_ext_r && ext_is_prog_r)
        else $error("high fetch not external");
    a_sfr_zero: assert property (undef_rd |=> sfr_rd_zero_r)
        else $error("undefined register read not zeroed");
    a_sfr_no_mem: assert property (sfr |=> !sel_sram_r && !sel_flash_r && !sel_ext_r)
        else $error("register access selected memory");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus ready timing wrong");
endmodule // fpad_props

bind flash_partition_address_decoder fpad_props #(.FLASH_KB(FLASH_KB)) i_fpad_props (.*);

/* core_model.sv */
// Core-side model issuing fetch, table-read, data-move and register accesses
`timescale 1ns/100ps
module core_model (
    input wire pclk,
    output reg acc_valid,
    output reg [1:0] acc_type,
    output reg acc_write,
    output reg acc_erase,
    output reg [15:0] acc_addr
);
    initial
    begin
        acc_valid = 1'b0;
        acc_type = 2'h0;
        acc_write = 1'b0;
        acc_erase = 1'b0;
        acc_addr = 16'h0000;
    end
    task issue(input [1:0] t, input w, input [15:0] a);
    begin
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_type <= t;
        acc_write <= w;
        acc_addr <= a;
        @(posedge pclk);
        acc_valid <= 1'b0;
        // Scrambled so a stale address never passes for a live one
        acc_addr <= ~a;
    end
    endtask
endmodule // core_model

/* testbench.sv */
// Self-checking bench for the flash partition address decoder
`timescale 1ns/100ps
module testbench;
    reg pclk, presetn, psel, penable, pwrite, prog_mode_pin;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [15:0] top;
    reg [5:0] v;
    wire [31:0] prdata;
    wire pready, acc_valid, acc_write, acc_erase;
    wire [1:0] acc_type;
    wire [15:0] acc_addr;
    wire [5:0] outs;
    integer miscompares, tests_run, c, pk;
    flash_partition_address_decoder i_flash_partition_address_decoder (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .prog_mode_pin(prog_mode_pin), .acc_valid(acc_valid), .acc_type(acc_type),
        .acc_write(acc_write), .acc_erase(acc_erase), .acc_addr(acc_addr),
        .sel_sram_r(outs[5]), .sel_flash_r(outs[4]), .sel_ext_r(outs[3]),
        .flash_offset_r(), .acc_denied_r(outs[2]), .ext_is_prog_r(outs[1]),
        .sfr_rd_zero_r(outs[0]));
    core_model i_core_model (.pclk(pclk), .acc_valid(acc_valid), .acc_type(acc_type),
        .acc_write(acc_write), .acc_erase(acc_erase), .acc_addr(acc_addr));
    task close_out;
    begin
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Look mid-cycle so ready and read data are settled
        @(negedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n = n + 1;
            @(negedge pclk);
        end
        rd = prdata;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            miscompares = miscompares + 1;
            close_out;
        end
    end
    endtask
    // Outputs pulse for the one cycle after the sampled access
    task acc(input [1:0] t, input w, input [15:0] a);
    begin
        i_core_model.issue(t, w, a);
        #1;
        v = outs;
    end
    endtask
    task t_default;
    begin
        acc(2'h2, 1'b1, 16'h0100);
        chk("sram", v, 6'h20);
        acc(2'h0, 1'b0, 16'h0100);
        chk("fetch low", v, 6'h10);
        acc(2'h1, 1'b0, 16'h7FFF);
        chk("table top", v, 6'h10);
        acc(2'h2, 1'b0, 16'hFFFF);
        chk("data ext", v, 6'h08);
        acc(2'h3, 1'b0, 16'h00A0);
        chk("sfr", v, 6'h01);
    end
    endtask
    task t_refused;
    begin
        apb(1'b1, 12'h004, 32'h0000_0016);
        apb(1'b0, 12'h004, 32'h0);
        chk("cfg", rd, 32'h0000_00FF);
        apb(1'b1, 12'h020, 32'h0000_00FF);
        apb(1'b0, 12'h000, 32'h0);
        chk("wsel", rd, 32'h0);
    end
    endtask
    task t_partition;
    begin
        prog_mode_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        for (c = 1; c < 7; c = c + 1)
        begin
            apb(1'b1, 12'h004, 32'hF8 | c);
            pk = 32 - (32 >> (c - 1));
            top = 16'h03FF + (16'h8000 >> (c - 1));
            apb(1'b0, 12'h010, 32'h0);
            chk("status", rd & 32'h3F07, {18'h0, pk[5:0], 5'h00, c[2:0]});
            acc(2'h2, 1'b0, top);
            chk("dflash top", v, 6'h10);
            acc(2'h2, 1'b0, top + 16'h0001);
            chk("past dflash", v, 6'h08);
            acc(2'h0, 1'b0, {pk[5:0], 10'h000});
            chk("fetch past", v, 6'h0A);
        end
        acc(2'h2, 1'b1, 16'h0400);
        chk("denied", v[2], 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h0000_00E6);
        apb(1'b0, 12'h004, 32'h0);
        chk("cfg", rd, 32'h0000_00E6);
        acc(2'h2, 1'b1, 16'h0400);
        chk("dflash wr", v, 6'h10);
        acc(2'h2, 1'b1, 16'h1000);
        chk("locked", v, 6'h04);
    end
    endtask
    task t_relocate;
    begin
        apb(1'b1, 12'h00C, 32'h3);
        acc(2'h0, 1'b0, 16'h8400);
        chk("reloc fetch", v, 6'h20);
        acc(2'h2, 1'b0, 16'h87FF);
        chk("reloc data", v, 6'h20);
        apb(1'b1, 12'h00C, 32'h0);
        acc(2'h2, 1'b0, 16'h0100);
        chk("mem off", v, 6'h08);
    end
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        prog_mode_pin = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_default;
        t_refused;
        t_partition;
        t_relocate;
        close_out;
    end
endmodule // testbench
